// file: src/dsg_defs.vh
// Constants for the deep-sleep clock gating block
// How it works
// - Each enable bit gates one unit's clock
// - Access to gated-off unit gives bus fault
// - Reset value is 0x00000040
// - Bit 16 enables converter clock in deep sleep
// - Bits 9:8 select converter sample rate
// - Rate field clamped to the supported maximum
// - Bit 6 enables hibernation module clock
// - Bit 3 enables watchdog clock, faults else
// - Reserved bits read only, read zero
// - Run, sleep, deep-sleep registers apply per mode
// - Sleep registers used only with auto gating
// - Register sits at offset 0x120, 32 bits
`ifndef DSG_DEFS_VH
`define DSG_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DSG_AW            12
`define DSG_OFF_RUN       12'h0_100
`define DSG_OFF_SLEEP     12'h0_110
`define DSG_OFF_DEEP      12'h0_120
`define DSG_OFF_CFG       12'h0_060
`define DSG_OFF_STAT      12'h0_200
`define DSG_OFF_MASK      12'h0_204

// ----------------------------------------
// Field layout
// ----------------------------------------
`define DSG_BIT_CONV      16
`define DSG_RATE_HI       9
`define DSG_RATE_LO       8
`define DSG_BIT_HIB       6
`define DSG_BIT_WDG       3
`define DSG_BIT_AUTO      27
`define DSG_WMASK         32'h0001_0348
`define DSG_RST_GATE      32'h0000_0040
`define DSG_RST_CFG       32'h0000_0000
`define DSG_RATE_MAX      2'h2
`define DSG_AUTO_MASK     32'h0800_0000
`define DSG_RST_ZERO      32'h0000_0000
`define DSG_RST_RATE      2'h0
`define DSG_RST_BIT       1'b0

// ----------------------------------------
// Modes and status bits
// ----------------------------------------
`define DSG_MODE_RUN      2'h0
`define DSG_MODE_SLEEP    2'h1
`define DSG_MODE_DEEP     2'h2
`define DSG_ST_CONV       0
`define DSG_ST_WDG        1
`define DSG_ST_BAD        2
`define DSG_ST_W          3

`endif

// file: src/dsg_top.v
// Deep-sleep clock gating controller with register port
`timescale 1ns/1ps
`default_nettype none
`include "dsg_defs.vh"

// ----------------------------------------
// Timing notes
// ----------------------------------------
// Register port:
//   A write is taken at the edge that sees WR high; the register holds
//   the new value after that edge and the clock enables follow one
//   edge later, because every output of this block is a flop.
//   A read is taken at the edge that sees RD high; RDATA carries the
//   value for exactly the next cycle and is zero in every other cycle.
//   The port never stalls, so reads and writes may come back to back.
// Power mode:
//   MODE arrives from another domain and passes three flops; the new
//   mode is adopted once the second and third flop agree, so a change
//   reaches the enables four to five cycles after it appears.
//   A mode code of three is handled like run mode.
// Gating choice:
//   With auto gating off the run register governs every mode, so a
//   sleep entry cannot silently switch units off behind software.
//   With auto gating on the register of the current mode is used.
// Faults:
//   A unit access while its clock is off raises BUS_FAULT for one
//   cycle and sets a sticky status bit. An access to an unmapped
//   offset of this port sets its own status bit as well.
//   A status bit that is written with one in the cycle its event
//   fires stays set, so no event is ever lost to a clear.
// Rate field:
//   Codes above the supported maximum are stored as the maximum, so
//   the converter never sees a rate it cannot keep up with.
// Reserved bits:
//   Only implemented bits are stored; the rest read back as zero.

module dsg_top (
	input  wire                CLK,
	input  wire                RST_B,
	input  wire [`DSG_AW-1:0]  ADDR,
	input  wire [31:0]         WDATA,
	input  wire                WR,
	input  wire                RD,
	output reg  [31:0]         RDATA,
	input  wire [1:0]          MODE,
	input  wire                CONV_ACC,
	input  wire                WDG_ACC,
	output reg                 CONV_CLK_EN,
	output reg                 HIB_CLK_EN,
	output reg                 WDG_CLK_EN,
	output reg  [1:0]          CONV_RATE,
	output reg                 BUS_FAULT,
	output reg                 IRQ
);

	reg  [31:0]          run_r;
	reg  [31:0]          slp_r;
	reg  [31:0]          deep_r;
	reg  [31:0]          cfg_r;
	reg  [`DSG_ST_W-1:0] stat_r;
	reg  [`DSG_ST_W-1:0] mask_r;
	reg  [1:0]           mode_s1_r;
	reg  [1:0]           mode_s2_r;
	reg  [1:0]           mode_s3_r;
	reg  [1:0]           mode_r;
	reg  [31:0]          act;
	reg  [31:0]          rd_nxt;
	reg  [`DSG_ST_W-1:0] ev;
	wire [31:0]          wv;
	wire                 auto;
	wire [1:0]           rate_in;
	wire                 hit_run;
	wire                 hit_slp;
	wire                 hit_deep;
	wire                 hit_cfg;
	wire                 hit_stat;
	wire                 hit_mask;
	wire                 hit_any;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// One hit line per mapped register; anything else is unmapped
	assign hit_run  = (ADDR == `DSG_OFF_RUN);
	assign hit_slp  = (ADDR == `DSG_OFF_SLEEP);
	assign hit_deep = (ADDR == `DSG_OFF_DEEP);
	assign hit_cfg  = (ADDR == `DSG_OFF_CFG);
	assign hit_stat = (ADDR == `DSG_OFF_STAT);
	assign hit_mask = (ADDR == `DSG_OFF_MASK);
	assign hit_any  = hit_run | hit_slp | hit_deep | hit_cfg | hit_stat |
	                  hit_mask;

	// ----------------------------------------
	// Mode pin synchroniser
	// ----------------------------------------
	// Mode comes from the power controller; change counts when s2 and s3 agree
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_s1_r <= `DSG_MODE_RUN;
			mode_s2_r <= `DSG_MODE_RUN;
			mode_s3_r <= `DSG_MODE_RUN;
			mode_r    <= `DSG_MODE_RUN;
		end else begin
			mode_s1_r <= MODE;
			mode_s2_r <= mode_s1_r;
			mode_s3_r <= mode_s2_r;
			if (mode_s2_r == mode_s3_r) begin
				mode_r <= mode_s3_r;
			end
		end
	end

	// ----------------------------------------
	// Gating registers
	// ----------------------------------------
	// Only writable bits are stored; reserved bits stay zero
	assign wv      = WDATA & `DSG_WMASK;
	assign rate_in = wv[`DSG_RATE_HI:`DSG_RATE_LO];

	// Rate codes above the limit are clamped to the maximum
	function [31:0] dsg_clamp;
		input [31:0] v;
		input [1:0]  r;
		begin
			dsg_clamp = v;
			if (r > `DSG_RATE_MAX) begin
				dsg_clamp[`DSG_RATE_HI:`DSG_RATE_LO] = `DSG_RATE_MAX;
			end
		end
	endfunction

	// Run-mode gating register, the fallback set
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			run_r <= `DSG_RST_GATE;
		end else if (WR && hit_run) begin
			run_r <= dsg_clamp(wv, rate_in);
		end
	end

	// Sleep-mode gating register
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			slp_r <= `DSG_RST_GATE;
		end else if (WR && hit_slp) begin
			slp_r <= dsg_clamp(wv, rate_in);
		end
	end

	// Deep-sleep gating register
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			deep_r <= `DSG_RST_GATE;
		end else if (WR && hit_deep) begin
			deep_r <= dsg_clamp(wv, rate_in);
		end
	end

	// Clock configuration, only the auto gating bit is kept
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_r <= `DSG_RST_CFG;
		end else if (WR && hit_cfg) begin
			cfg_r <= WDATA & `DSG_AUTO_MASK;
		end
	end

	// ----------------------------------------
	// Active gating selection
	// ----------------------------------------
	assign auto = cfg_r[`DSG_BIT_AUTO];

	// Mode picks the register; without auto gating run settings
	always @* begin
		act = run_r;
		if (auto) begin
			case (mode_r)
				`DSG_MODE_SLEEP: act = slp_r;
				`DSG_MODE_DEEP:  act = deep_r;
				default:         act = run_r;
			endcase
		end
	end

	// ----------------------------------------
	// Fault events
	// ----------------------------------------
	// Access to an unclocked converter or watchdog faults
	always @* begin
		ev = {`DSG_ST_W{1'b0}};
		ev[`DSG_ST_CONV] = CONV_ACC & ~act[`DSG_BIT_CONV];
		ev[`DSG_ST_WDG]  = WDG_ACC & ~act[`DSG_BIT_WDG];
		ev[`DSG_ST_BAD]  = (WR | RD) & ~hit_any;
	end

	// Sticky status, write one to clear, set wins over clear
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			stat_r <= {`DSG_ST_W{1'b0}};
		end else if (WR && hit_stat) begin
			stat_r <= (stat_r & ~WDATA[`DSG_ST_W-1:0]) | ev;
		end else begin
			stat_r <= stat_r | ev;
		end
	end

	// Interrupt mask, same layout as the status register
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			mask_r <= {`DSG_ST_W{1'b0}};
		end else if (WR && hit_mask) begin
			mask_r <= WDATA[`DSG_ST_W-1:0];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped reads return zero
	always @* begin
		case (ADDR)
			`DSG_OFF_RUN:   rd_nxt = run_r;
			`DSG_OFF_SLEEP: rd_nxt = slp_r;
			`DSG_OFF_DEEP:  rd_nxt = deep_r;
			`DSG_OFF_CFG:   rd_nxt = cfg_r;
			`DSG_OFF_STAT:  rd_nxt = {{(32-`DSG_ST_W){1'b0}}, stat_r};
			`DSG_OFF_MASK:  rd_nxt = {{(32-`DSG_ST_W){1'b0}}, mask_r};
			default:        rd_nxt = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Read data stands one cycle after the strobe, zero otherwise
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= `DSG_RST_ZERO;
		end else begin
			RDATA <= RD ? rd_nxt : `DSG_RST_ZERO;
		end
	end

	// Converter clock enable
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CONV_CLK_EN <= `DSG_RST_BIT;
		end else begin
			CONV_CLK_EN <= act[`DSG_BIT_CONV];
		end
	end

	// Hibernation clock enable
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			HIB_CLK_EN <= `DSG_RST_BIT;
		end else begin
			HIB_CLK_EN <= act[`DSG_BIT_HIB];
		end
	end

	// Watchdog clock enable
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			WDG_CLK_EN <= `DSG_RST_BIT;
		end else begin
			WDG_CLK_EN <= act[`DSG_BIT_WDG];
		end
	end

	// Converter sample rate code
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CONV_RATE <= `DSG_RST_RATE;
		end else begin
			CONV_RATE <= act[`DSG_RATE_HI:`DSG_RATE_LO];
		end
	end

	// One-cycle fault pulse for an access to a gated unit
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			BUS_FAULT <= `DSG_RST_BIT;
		end else begin
			BUS_FAULT <= ev[`DSG_ST_CONV] | ev[`DSG_ST_WDG];
		end
	end

	// Level interrupt while any unmasked status bit is set
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ <= `DSG_RST_BIT;
		end else begin
			IRQ <= |(stat_r & mask_r);
		end
	end

endmodule
`default_nettype wire

// file: tb/dsg_chk_properties.sv
// Port assertions for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_chk (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic [11:0] ADDR,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        CONV_ACC,
	input wire logic        WDG_ACC,
	input wire logic        CONV_CLK_EN,
	input wire logic        HIB_CLK_EN,
	input wire logic        WDG_CLK_EN,
	input wire logic [1:0]  CONV_RATE,
	input wire logic        BUS_FAULT,
	input wire logic        IRQ
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	// ----
	// Port relations
	// ----
	idle_data_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
		else $error("read data outside its slot");
	rsv_zero_a: assert property (RD && ADDR == 12'h120 |=>
		(RDATA & 32'hFFFE_FCB7) == 32'h0000_0000) else $error("reserved bit set");
	rate_cap_a: assert property (CONV_RATE != 2'h3)
		else $error("rate above limit");
	hib_reset_a: assert property ($rose(RST_B) |=> HIB_CLK_EN)
		else $error("hibernation clock off after reset");
	conv_fault_a: assert property (CONV_ACC && !CONV_CLK_EN ##1 !CONV_CLK_EN
		|-> BUS_FAULT) else $error("no fault on gated converter");
	wdg_fault_a: assert property (WDG_ACC && !WDG_CLK_EN ##1 !WDG_CLK_EN
		|-> BUS_FAULT) else $error("no fault on gated watchdog");
	no_fault_a: assert property (!CONV_ACC && !WDG_ACC |=> !BUS_FAULT)
		else $error("fault without access");
	irq_hold_a: assert property ($fell(IRQ) |-> $past(WR, 2))
		else $error("interrupt dropped without write");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 0, rst_b = 0, wr = 0, rd = 0, c_acc = 0, w_acc = 0;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  mode = 0, rate;
	logic        c_en, h_en, w_en, flt, irq;
	int          err_total = 0, n_tests = 0;
	// Clock and design
	always #5 clk = ~clk;
	dsg_top dsg_top_i (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .MODE(mode), .CONV_ACC(c_acc),
		.WDG_ACC(w_acc), .CONV_CLK_EN(c_en), .HIB_CLK_EN(h_en),
		.WDG_CLK_EN(w_en), .CONV_RATE(rate), .BUS_FAULT(flt), .IRQ(irq));
	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wreg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task en(input logic [4:0] e);
		repeat (6) @(posedge clk);
		#1 chk({27'h0, c_en, h_en, w_en, rate}, {27'h0, e});
	endtask
	task summarize;
		$display("%0d checks, %0d mismatches", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rreg(12'h120, 32'h0000_0040);
		en(5'b01000);
		wreg(12'h120, 32'hFFFF_FFFF);
		rreg(12'h120, 32'h0001_0248);
		@(posedge clk) mode <= 2'h2;
		en(5'b01000);
		wreg(12'h060, 32'h0800_0000);
		en(5'b11110);
		for (int i = 0; i < 3; i++) begin
			wreg(12'h120, {15'h0, 1'b1, 6'h0, i[1:0], 8'h0});
			en({3'b100, i[1:0]});
		end
		@(posedge clk) mode <= 2'h1;
		en(5'b01000);
		$display("gating tests done");
		wreg(12'h110, 32'h0000_0000);
		en(5'b00000);
		@(posedge clk) c_acc <= 1'b1;
		@(posedge clk) c_acc <= 1'b0;
		#1 chk(flt, 1);
		@(posedge clk) w_acc <= 1'b1;
		@(posedge clk) w_acc <= 1'b0;
		#1 chk(flt, 1);
		wreg(12'h204, 32'h0000_0003);
		@(posedge clk) #1 chk(irq, 1);
		rreg(12'h7FC, 32'h0000_0000);
		rreg(12'h200, 32'h0000_0007);
		wreg(12'h200, 32'h0000_0007);
		repeat (2) @(posedge clk);
		#1 chk(irq, 0);
		$display("fault tests done");
		summarize;
	end
	// Watchdog against a hang
	initial begin
		#100us;
		err_total++;
		summarize;
	end
endmodule
bind dsg_top dsg_chk dsg_chk_i (.*);
`default_nettype wire
